/* e1ec_bank_chk.sv */
`timescale 1ns/100ps
// Port-level checks on the counter bank; it sees only the top module's ports.
module e1ec_bank_chk (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Write channels.
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	// Read channels.
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [e1ec_pkg::DATA_W-1:0] rdata,
	input wire logic [1:0] rresp,
	// Interrupt.
	input wire logic irq
);
	// All checks share the one clock and its reset.
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Both write halves are taken on one edge.
	sequence wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence

	// A read address is taken, and with it any clear.
	sequence rd_taken;
		arvalid && arready;
	endsequence

	// The response comes after one commit cycle, never sooner.
	a_write_answer: assert property (wr_taken |=> !bvalid ##1 bvalid)
		else $error("write response not two cycles after the write");
	a_read_answer: assert property (rd_taken |=> rvalid)
		else $error("read data not one cycle after the address");
	a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data changed before it was taken");
	a_read_block: assert property (rvalid |-> !arready)
		else $error("read address accepted while data is pending");
	a_write_block: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while a response is pending");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response changed before it was taken");
	// Every register of the bank is at most one byte wide.
	a_byte_wide: assert property (rvalid |-> rdata[31:8] == 24'h000000)
		else $error("read data has bits above the low byte");
	a_decerr_zero: assert property (rvalid && rresp == e1ec_pkg::RESP_DECERR |-> rdata == 32'h00000000)
		else $error("refused read returned nonzero data");
	a_irq_reset: assert property ($rose(aresetn) |-> !irq)
		else $error("interrupt high straight after reset");
endmodule

bind e1ec_counter_bank e1ec_bank_chk u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
	.bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .rresp, .irq);

/* e1ec_counter_bank.sv */
`timescale 1ns/100ps
// Error event counter bank for one E1 channel, reached over AXI4-Lite.
module e1ec_counter_bank (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel.
	input wire logic awvalid,
	output logic awready,
	input wire logic [e1ec_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// Write data channel.
	input wire logic wvalid,
	output logic wready,
	input wire logic [e1ec_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	// Write response channel.
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// Read address channel.
	input wire logic arvalid,
	output logic arready,
	input wire logic [e1ec_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// Read data channel.
	output logic rvalid,
	input wire logic rready,
	output logic [e1ec_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	// One-cycle events from the framer and link controllers.
	input wire e1ec_pkg::e1ec_events_t events,
	// Interrupt level.
	output logic irq
);

	// Decodes a byte address into a hit on one register index.
	// Bits below the word and above the index must be zero.
	function automatic logic reg_hit(
		input logic [e1ec_pkg::ADDR_W-1:0] addr,
		input logic [e1ec_pkg::IDX_W-1:0] idx
	);
		logic ok;
		ok = (addr[e1ec_pkg::IDX_LSB-1:0] == '0);
		ok = ok && (addr[e1ec_pkg::ADDR_W-1:e1ec_pkg::IDX_MSB+1] == '0);
		return ok && (addr[e1ec_pkg::IDX_MSB:e1ec_pkg::IDX_LSB] == idx);
	endfunction

	// Write channel state and held request.
	e1ec_pkg::e1ec_wr_state_t wr_state;
	logic aw_held; // Address taken, waiting for data or response.
	logic w_held; // Data taken, waiting for address or response.
	logic [e1ec_pkg::ADDR_W-1:0] aw_addr_q; // Held write address.
	logic [e1ec_pkg::DATA_W-1:0] w_data_q; // Held write data.
	logic [3:0] w_strb_q; // Held byte enables.
	logic do_write; // Both halves present, commit this cycle.

	// Read channel state.
	e1ec_pkg::e1ec_rd_state_t rd_state;
	logic rd_take; // Read address accepted this cycle.

	// Software-visible control and status.
	logic [e1ec_pkg::STAT_W-1:0] irq_mask; // Written by software.
	logic [e1ec_pkg::STAT_W-1:0] irq_status; // Sticky event bits.
	logic [e1ec_pkg::STAT_W-1:0] status_set; // Event pulses.

	// Read decode of the accepted address.
	logic hit_zv_high;
	logic hit_zv_low;
	logic hit_link2;
	logic hit_link3;
	logic hit_status;
	logic hit_mask;

	// Counter state.
	logic [e1ec_pkg::WIDE_W-1:0] zv_count; // Live 16-bit count.
	logic zv_at_max;
	logic [e1ec_pkg::BYTE_W-1:0] link2_count;
	logic link2_at_max;
	logic [e1ec_pkg::BYTE_W-1:0] link3_count;
	logic link3_at_max;

	// Low byte frozen by a high-byte read, and whether a pair is open.
	logic [e1ec_pkg::BYTE_W-1:0] zv_low_shadow;
	logic zv_pair_open;

	// Protection bits carry no meaning for this block.
	logic unused_prot;
	assign unused_prot = ^{awprot, arprot};

	// ------------------------------------------------------------
	// Write path.
	// ------------------------------------------------------------

	// Each half is accepted on its own; the other may come first.
	assign awready = (wr_state == e1ec_pkg::WR_COLLECT) && !aw_held;
	assign wready = (wr_state == e1ec_pkg::WR_COLLECT) && !w_held;
	assign bvalid = (wr_state == e1ec_pkg::WR_RESP);

	// The write is committed in the cycle after both halves are taken.
	// This costs a cycle but keeps the decode off the input pins.
	assign do_write = (wr_state == e1ec_pkg::WR_COLLECT) && aw_held && w_held;

	// Write channel sequencing.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state <= e1ec_pkg::WR_COLLECT;
		end else begin
			unique case (wr_state)
				e1ec_pkg::WR_COLLECT: begin
					// Move on once both halves are in.
					if (do_write) begin
						wr_state <= e1ec_pkg::WR_RESP;
					end
				end
				e1ec_pkg::WR_RESP: begin
					// Hold the response until the master takes it.
					if (bready) begin
						wr_state <= e1ec_pkg::WR_COLLECT;
					end
				end
			endcase
		end
	end

	// Capture of the write address.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr_q <= '0;
		end else if (awvalid && awready) begin
			aw_held <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (bvalid && bready) begin
			aw_held <= 1'b0;
		end
	end

	// Capture of the write data.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (wvalid && wready) begin
			w_held <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (bvalid && bready) begin
			w_held <= 1'b0;
		end
	end

	// Write response code. Counters and status are read-only, so a write
	// to them is answered OKAY and ignored; unknown addresses get DECERR.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bresp <= e1ec_pkg::RESP_OKAY;
		end else if (do_write) begin
			if (reg_hit(aw_addr_q, e1ec_pkg::IDX_ZV_HIGH) ||
				reg_hit(aw_addr_q, e1ec_pkg::IDX_ZV_LOW) ||
				reg_hit(aw_addr_q, e1ec_pkg::IDX_LINK2) ||
				reg_hit(aw_addr_q, e1ec_pkg::IDX_LINK3) ||
				reg_hit(aw_addr_q, e1ec_pkg::IDX_IRQ_STATUS) ||
				reg_hit(aw_addr_q, e1ec_pkg::IDX_IRQ_MASK)) begin
				bresp <= e1ec_pkg::RESP_OKAY;
			end else begin
				bresp <= e1ec_pkg::RESP_DECERR;
			end
		end
	end

	// Interrupt mask register, only the low byte lane matters.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask <= e1ec_pkg::MASK_RST;
		end else if (do_write && w_strb_q[0] &&
			reg_hit(aw_addr_q, e1ec_pkg::IDX_IRQ_MASK)) begin
			irq_mask <= w_data_q[e1ec_pkg::STAT_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// Read path.
	// ------------------------------------------------------------

	// One read at a time; a new address is taken only when idle.
	assign arready = (rd_state == e1ec_pkg::RD_IDLE);
	assign rvalid = (rd_state == e1ec_pkg::RD_DATA);
	assign rd_take = arvalid && arready;

	// Decode of the read address, shared by data and side effects.
	assign hit_zv_high = rd_take && reg_hit(araddr, e1ec_pkg::IDX_ZV_HIGH);
	assign hit_zv_low = rd_take && reg_hit(araddr, e1ec_pkg::IDX_ZV_LOW);
	assign hit_link2 = rd_take && reg_hit(araddr, e1ec_pkg::IDX_LINK2);
	assign hit_link3 = rd_take && reg_hit(araddr, e1ec_pkg::IDX_LINK3);
	assign hit_status = rd_take && reg_hit(araddr, e1ec_pkg::IDX_IRQ_STATUS);
	assign hit_mask = rd_take && reg_hit(araddr, e1ec_pkg::IDX_IRQ_MASK);

	// Read channel sequencing.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state <= e1ec_pkg::RD_IDLE;
		end else begin
			unique case (rd_state)
				e1ec_pkg::RD_IDLE: begin
					// Data is ready the cycle after the address.
					if (rd_take) begin
						rd_state <= e1ec_pkg::RD_DATA;
					end
				end
				e1ec_pkg::RD_DATA: begin
					// Hold data until the master takes it.
					if (rready) begin
						rd_state <= e1ec_pkg::RD_IDLE;
					end
				end
			endcase
		end
	end

	// Read data mux, sampled at acceptance so the value returned is the
	// one that the clear below throws away. Upper bits read as zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata <= e1ec_pkg::DATA_RST;
			rresp <= e1ec_pkg::RESP_OKAY;
		end else if (rd_take) begin
			rdata <= e1ec_pkg::DATA_RST;
			rresp <= e1ec_pkg::RESP_OKAY;
			if (hit_zv_high) begin
				rdata[e1ec_pkg::BYTE_W-1:0] <= zv_count[e1ec_pkg::WIDE_W-1:e1ec_pkg::BYTE_W];
			end else if (hit_zv_low) begin
				// Inside a pair the frozen byte is returned. A lone low
				// read shows the live byte and clears nothing.
				if (zv_pair_open) begin
					rdata[e1ec_pkg::BYTE_W-1:0] <= zv_low_shadow;
				end else begin
					rdata[e1ec_pkg::BYTE_W-1:0] <= zv_count[e1ec_pkg::BYTE_W-1:0];
				end
			end else if (hit_link2) begin
				rdata[e1ec_pkg::BYTE_W-1:0] <= link2_count;
			end else if (hit_link3) begin
				rdata[e1ec_pkg::BYTE_W-1:0] <= link3_count;
			end else if (hit_status) begin
				rdata[e1ec_pkg::STAT_W-1:0] <= irq_status;
			end else if (hit_mask) begin
				rdata[e1ec_pkg::STAT_W-1:0] <= irq_mask;
			end else begin
				// Nothing lives here.
				rresp <= e1ec_pkg::RESP_DECERR;
			end
		end
	end

	// ------------------------------------------------------------
	// Counters.
	// ------------------------------------------------------------

	// The 16-bit zero violation count. The high-byte read restarts it,
	// and the low byte of the same snapshot waits in the shadow for the
	// second read of the pair, so the two bytes always agree.
	e1ec_sat_counter #(
		.W(e1ec_pkg::WIDE_W)
	) u_zv_counter (
		.aclk(aclk),
		.aresetn(aresetn),
		.inc(events.zero_violation),
		.clr(hit_zv_high),
		.count(zv_count),
		.at_max(zv_at_max)
	);

	// Shadow of the low byte for the ordered read pair. A low read
	// closes the pair and empties the shadow, which finishes the clear.
	// A second high read before the low read simply re-snapshots.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			zv_low_shadow <= e1ec_pkg::BYTE_RST;
			zv_pair_open <= 1'b0;
		end else if (hit_zv_high) begin
			zv_low_shadow <= zv_count[e1ec_pkg::BYTE_W-1:0];
			zv_pair_open <= 1'b1;
		end else if (hit_zv_low && zv_pair_open) begin
			zv_low_shadow <= e1ec_pkg::BYTE_RST;
			zv_pair_open <= 1'b0;
		end
	end

	// Checksum error count of the second data-link controller.
	e1ec_sat_counter #(
		.W(e1ec_pkg::BYTE_W)
	) u_link2_counter (
		.aclk(aclk),
		.aresetn(aresetn),
		.inc(events.link2_fcs_error),
		.clr(hit_link2),
		.count(link2_count),
		.at_max(link2_at_max)
	);

	// Checksum error count of the third data-link controller.
	e1ec_sat_counter #(
		.W(e1ec_pkg::BYTE_W)
	) u_link3_counter (
		.aclk(aclk),
		.aresetn(aresetn),
		.inc(events.link3_fcs_error),
		.clr(hit_link3),
		.count(link3_count),
		.at_max(link3_at_max)
	);

	// ------------------------------------------------------------
	// Interrupts.
	// ------------------------------------------------------------

	// Event pulses. The saturation bit flags an event that was dropped
	// because its counter was parked at all ones, so software knows the
	// count it reads is a floor, not the true figure.
	always_comb begin
		status_set = '0;
		status_set[e1ec_pkg::ST_ZV] = events.zero_violation;
		status_set[e1ec_pkg::ST_LINK2] = events.link2_fcs_error;
		status_set[e1ec_pkg::ST_LINK3] = events.link3_fcs_error;
		// An event that meets the clearing read is counted as one, not dropped.
		status_set[e1ec_pkg::ST_SAT] = (events.zero_violation && zv_at_max && !hit_zv_high) ||
			(events.link2_fcs_error && link2_at_max && !hit_link2) ||
			(events.link3_fcs_error && link3_at_max && !hit_link3);
	end

	// Sticky status, cleared by reading it; a fresh event wins.
	e1ec_sticky #(
		.W(e1ec_pkg::STAT_W)
	) u_status (
		.aclk(aclk),
		.aresetn(aresetn),
		.set(status_set),
		.clr(hit_status),
		.flags(irq_status)
	);

	// Interrupt level, registered so it is glitch free at the pin.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

endmodule

/* e1ec_counter_bank_tb.sv */
`timescale 1ns/100ps
// Self-checking bench for the counter bank over its register bus.
module e1ec_counter_bank_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
	logic [31:0] wdata = 32'h00000000, rdata;
	logic [3:0] wstrb = 4'hF;
	logic [2:0] awprot = 3'h0, arprot = 3'h0;
	logic [1:0] bresp, rresp;
	e1ec_pkg::e1ec_events_t events = '0;
	int fail_count = 0, check_count = 0, cyc = 0;
	// Register byte addresses; the 0x3000 one maps to nothing.
	localparam logic [15:0] A_HI = 16'h2440, A_LO = 16'h2444, A_L2 = 16'h2470, A_L3 = 16'h24B0;
	localparam logic [15:0] A_ST = 16'h24C0, A_MK = 16'h24C4, A_NONE = 16'h3000;
	localparam logic [1:0] OK = e1ec_pkg::RESP_OKAY, DE = e1ec_pkg::RESP_DECERR;

	e1ec_counter_bank DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready, .wdata,
		.wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid, .rready, .rdata,
		.rresp, .events, .irq);

	// Clock at 200 MHz.
	initial begin
		forever #2.5 aclk = ~aclk;
	end

	// A hang is cut short well past the several hundred cycles the tests need.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			end_sim();
		end
	end

	// Compares one bus word with its expected value.
	task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Compares one response code.
	task automatic chk_r(input logic [1:0] got, input logic [1:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("ERROR at %0t: resp %h expected %h", $time, got, exp);
		end
	endtask

	// One bus write; both halves offered together, each dropped once it is taken.
	// Ready is looked at mid-cycle, where it is settled for the coming edge.
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_wait;
		logic w_wait;
		logic aw_go;
		logic w_go;
		aw_wait = 1'b1;
		w_wait = 1'b1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		bready <= 1'b1;
		while (aw_wait || w_wait) begin
			@(negedge aclk);
			aw_go = aw_wait && awready;
			w_go = w_wait && wready;
			@(posedge aclk);
			if (aw_go) begin
				awvalid <= 1'b0;
				aw_wait = 1'b0;
			end
			if (w_go) begin
				wvalid <= 1'b0;
				w_wait = 1'b0;
			end
		end
		do @(negedge aclk); while (!bvalid);
		chk_r(bresp, er);
		@(posedge aclk);
		bready <= 1'b0;
		// One idle edge, so the next call never raises bready in this time step.
		@(posedge aclk);
	endtask

	// One bus read, judged while the data stands.
	task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (!rvalid);
		chk_d(rdata, ed);
		chk_r(rresp, er);
		@(posedge aclk);
		rready <= 1'b0;
		// One idle edge, so the next call never raises rready in this time step.
		@(posedge aclk);
	endtask

	// Holds the given event lines high for n cycles, one event per cycle.
	task automatic pulse(input logic [2:0] e, input int n);
		events <= e;
		repeat (n) @(posedge aclk);
		events <= '0;
		@(posedge aclk);
	endtask

	// Every register is zero after reset; a bad address is refused.
	task automatic t_reset();
		rd(A_HI, 32'h00000000, OK);
		rd(A_LO, 32'h00000000, OK);
		rd(A_L2, 32'h00000000, OK);
		rd(A_L3, 32'h00000000, OK);
		rd(A_ST, 32'h00000000, OK);
		rd(A_MK, 32'h00000000, OK);
		rd(A_NONE, 32'h00000000, DE);
		wr(A_NONE, 32'h0000000F, DE);
		$display("test reset done");
	endtask

	// Masked events stay quiet; an unmasked one raises the level until read.
	task automatic t_irq();
		wr(A_MK, 32'h00000002, OK);
		rd(A_MK, 32'h00000002, OK);
		pulse(3'h4, 1);
		// The level is judged mid-cycle, after the edge that registers it.
		@(negedge aclk);
		chk_d({31'h0, irq}, 32'h00000000);
		@(posedge aclk);
		pulse(3'h2, 1);
		@(negedge aclk);
		chk_d({31'h0, irq}, 32'h00000001);
		@(posedge aclk);
		rd(A_ST, 32'h00000003, OK);
		@(negedge aclk);
		chk_d({31'h0, irq}, 32'h00000000);
		@(posedge aclk);
		rd(A_L2, 32'h00000001, OK);
		rd(A_HI, 32'h00000000, OK);
		rd(A_LO, 32'h00000001, OK);
		$display("test interrupt done");
	endtask

	// A count past one byte splits over the two registers and clears as a pair.
	task automatic t_wide();
		pulse(3'h4, 260);
		wr(A_HI, 32'h000000FF, OK);
		rd(A_HI, 32'h00000001, OK);
		pulse(3'h4, 2);
		rd(A_LO, 32'h00000004, OK);
		rd(A_LO, 32'h00000002, OK);
		rd(A_HI, 32'h00000000, OK);
		rd(A_LO, 32'h00000002, OK);
		rd(A_HI, 32'h00000000, OK);
		rd(A_LO, 32'h00000000, OK);
		$display("test wide counter done");
	endtask

	// Link counters count apart and clear on read; the link 3 counter stops at all ones.
	task automatic t_links();
		pulse(3'h2, 5);
		pulse(3'h1, 7);
		rd(A_L2, 32'h00000005, OK);
		rd(A_L3, 32'h00000007, OK);
		rd(A_L2, 32'h00000000, OK);
		rd(A_L3, 32'h00000000, OK);
		pulse(3'h1, 260);
		rd(A_L3, 32'h000000FF, OK);
		// Zero violation, both link errors and the dropped-event bit are all pending.
		rd(A_ST, 32'h0000000F, OK);
		$display("test link counters done");
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_irq();
		t_wide();
		t_links();
		end_sim();
	end
endmodule

/* e1ec_pkg.sv */
// Functional notes
// - Keep 16-bit zero violation event count.
// - Low count byte at its own register.
// - High count byte at separate register.
// - Zero violation count clears when read.
// - Ordered high-then-low read pair clears count.
// - Count link 2 checksum errors, clear on read.
// - Count link 3 checksum errors, clear on read.
package e1ec_pkg;

	// Bus and field widths.
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int WIDE_W = 16;
	localparam int IDX_W = 12;
	localparam int STAT_W = 4;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_ZV_HIGH = 12'h910;
	localparam logic [IDX_W-1:0] IDX_ZV_LOW = 12'h911;
	localparam logic [IDX_W-1:0] IDX_LINK2 = 12'h91C;
	localparam logic [IDX_W-1:0] IDX_LINK3 = 12'h92C;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'h930;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h931;

	// Address bit positions of the word index.
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = IDX_LSB + IDX_W - 1;

	// Interrupt status bit positions.
	localparam int ST_ZV = 0;
	localparam int ST_LINK2 = 1;
	localparam int ST_LINK3 = 2;
	localparam int ST_SAT = 3;

	// Reset values.
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
	localparam logic [WIDE_W-1:0] WIDE_RST = 16'h0000;
	localparam logic [STAT_W-1:0] MASK_RST = 4'h0;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;

	// Bus response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Events from the receive framer and the data-link controllers.
	typedef struct packed {
		logic zero_violation;
		logic link2_fcs_error;
		logic link3_fcs_error;
	} e1ec_events_t;

	// Write channel states.
	typedef enum logic [1:0] {
		WR_COLLECT = 2'h1,
		WR_RESP = 2'h2
	} e1ec_wr_state_t;

	// Read channel states.
	typedef enum logic [1:0] {
		RD_IDLE = 2'h1,
		RD_DATA = 2'h2
	} e1ec_rd_state_t;

endpackage

/* e1ec_sat_counter.sv */
`timescale 1ns/100ps
// Saturating event counter with a clear that keeps a same-cycle event.
module e1ec_sat_counter #(
	parameter int W = 8
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Control.
	input wire logic inc,
	input wire logic clr,
	// State.
	output logic [W-1:0] count,
	output logic at_max
);

	// All ones means the counter is parked.
	assign at_max = &count;

	// A clear restarts at one if an event lands in the same cycle, so
	// nothing that happens during the read is lost.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
		end else if (clr) begin
			count <= inc ? W'(1) : '0;
		end else if (inc && !at_max) begin
			count <= count + W'(1);
		end
	end

endmodule

/* e1ec_sticky.sv */
`timescale 1ns/100ps
// Sticky status bits: set wins over a clear in the same cycle.
module e1ec_sticky #(
	parameter int W = 4
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Control.
	input wire logic [W-1:0] set,
	input wire logic clr,
	// State.
	output logic [W-1:0] flags
);

	// The clear drops old bits, the OR keeps any fresh event.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~{W{clr}}) | set;
		end
	end

endmodule
